// ===== rtl/epi_pkg.sv
/*
 * Shared constants and types for the configuration image register block.
 * Assumes an 8-bit register space behind a two-wire serial target.
 */
package epi_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_NV_CONTROL = 8'h88;
	localparam logic [7:0] REG_UNLOCK_KEY = 8'h90;
	localparam logic [7:0] REG_COMMIT_PAGE = 8'h91;
	localparam logic [7:0] REG_CAP_HIGH = 8'hc7;
	localparam logic [7:0] REG_CAP_LOW = 8'hc8;

	// ------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------
	localparam int unsigned CTRL_PROGRAM_BIT = 0;
	localparam int unsigned CTRL_COMMIT_BIT = 1;
	localparam int unsigned CTRL_LOAD_DONE_BIT = 7;
	localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hea;
	localparam logic [3:0] COMMIT_PAGE_RESET = 4'h0;
	localparam logic [9:0] CAP_RESET = 10'h000;
	localparam logic [7:0] KEY_RESET = 8'h00;

	// ------------------------------------------------------------
	// Image layout
	// ------------------------------------------------------------
	localparam int unsigned PAGE_COUNT = 6;
	localparam int unsigned COMMON_BYTES = 39;
	localparam int unsigned PAGE_BYTES = 51;
	localparam int unsigned IMAGE_BYTES = COMMON_BYTES + PAGE_COUNT * PAGE_BYTES;
	localparam logic [3:0] IMG_PART_ID_0 = 4'h0;
	localparam logic [3:0] IMG_PART_ID_3 = 4'h3;
	localparam logic [3:0] IMG_CHECKSUM = 4'h4;
	localparam logic [3:0] IMG_COUNT = 4'h5;
	localparam logic [3:0] IMG_REVISION = 4'hc;
	localparam logic [3:0] IMG_STARTUP = 4'hd;
	localparam logic [3:0] IMG_LOAD_END = 4'he;

	// ------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	// Startup byte, top bit first
	typedef struct packed {
		logic sync_auto;
		logic sync_mute;
		logic outputs_on_after_lock;
		logic pll_start_style;
		logic automatic_startup;
		logic pll_a_lock_loss_mask;
		logic pll_a_signal_loss_mask;
		logic pll_a_calibration_mask;
	} epi_startup_type;

	// Common fields read back from the image
	typedef struct packed {
		logic [31:0] part_identifier;
		logic [7:0] image_checksum;
		logic [7:0] image_count;
		logic [7:0] image_revision;
		epi_startup_type startup;
	} epi_fields_type;

	// Serial target states
	typedef enum logic [3:0] {
		SER_IDLE = 4'b0000,
		SER_ADDR = 4'b0001,
		SER_ADDR_ACK = 4'b0010,
		SER_REG = 4'b0011,
		SER_REG_ACK = 4'b0100,
		SER_WDATA = 4'b0101,
		SER_WDATA_ACK = 4'b0110,
		SER_RDATA = 4'b0111,
		SER_RDATA_ACK = 4'b1000
	} epi_ser_type;

	// Image loader states
	typedef enum logic [0:0] {
		LD_RUN = 1'b0,
		LD_DONE = 1'b1
	} epi_load_type;

endpackage

// ===== rtl/epi_image_mem.sv
/*
 * Byte memory holding the configuration image.
 * Assumes one writer and one reader on the same clock; read data is registered.
 */
`timescale 1ns/100ps
`default_nettype none

module epi_image_mem
	import epi_pkg::*;
#(
	parameter int unsigned DEPTH = IMAGE_BYTES,
	parameter int unsigned WIDTH = 8,
	parameter int unsigned AW = 9
)
(
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Write port
	input wire logic wr_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	// Read port
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (DEPTH < IMAGE_BYTES || (2 ** AW) < DEPTH)
	begin : g_bad_size
		$error("epi_image_mem: depth or address width too small");
	end

	// Storage array
	logic [WIDTH-1:0] mem [DEPTH];
	// Next read data
	logic [WIDTH-1:0] next_rd_data;

	// Read lookup, out of range reads zero
	always_comb
	begin
		next_rd_data = '0;
		if (32'(rd_addr_i) < DEPTH)
			next_rd_data = mem[rd_addr_i];
	end

	// Array write
	always_ff @(posedge sys_clk_i)
	begin
		if (ce_i && wr_i && 32'(wr_addr_i) < DEPTH)
			mem[wr_addr_i] <= wr_data_i;
	end

	// Read register
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rd_data_o <= '0;
		else if (ce_i)
			rd_data_o <= next_rd_data;
	end

endmodule // epi_image_mem

`default_nettype wire

// ===== rtl/epi_image_regs.sv
/*
 * Configuration image registers: serial target, commit page, crystal
 * load readback, unlock-guarded program trigger and common image loader.
 * Assumes open-drain wiring of sda outside and one system clock.
 */
// Function
// - Four-bit commit page steers commit region
// - Six pages; two straps pick power-up page
// - Ten-bit crystal load value, read-only, split
// - Common bytes first, then six pages
// - Bytes zero-three hold part identifier, MSB first
// - Byte four checksum, byte five count
// - Byte thirteen holds startup and mask flags
`timescale 1ns/100ps
`default_nettype none

module epi_image_regs
	import epi_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h50,
	parameter int unsigned AW = 9
)
(
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Page strap pins
	input wire logic [1:0] page_strap_i,
	// Crystal load value from trim logic
	input wire logic [9:0] crystal_load_cap_value_i,
	// Image byte write port
	input wire logic img_wr_i,
	input wire logic [AW-1:0] img_addr_i,
	input wire logic [7:0] img_data_i,
	// Commit and program requests
	output logic [3:0] commit_page_o,
	output logic [AW-1:0] commit_base_o,
	output logic commit_start_o,
	output logic program_start_o,
	// Power-up state
	output logic [1:0] power_up_page_o,
	output epi_fields_type image_fields_o,
	output logic image_valid_o
);

	// ------------------------------------------------------------
	// Checks and helpers
	// ------------------------------------------------------------
	if ((2 ** AW) < IMAGE_BYTES)
	begin : g_bad_aw
		$error("epi_image_regs: address width too small for image");
	end

	// Base of a page inside the image
	function automatic logic [AW-1:0] page_base(input logic [3:0] page);
		page_base = AW'(COMMON_BYTES + 32'(page) * PAGE_BYTES);
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pin_ff1, pin_ff2, pin_ff3, pin_filt, pin_prev;
	logic [3:0] next_pin_filt;
	logic scl_f, sda_f, scl_p, sda_p;
	logic start_det, stop_det, scl_rise, scl_fall;

	// Accept a change only once stages two and three agree
	always_comb
	begin
		next_pin_filt = ((pin_ff2 ~^ pin_ff3) & pin_ff3) | ((pin_ff2 ^ pin_ff3) & pin_filt);
	end

	// Three-stage capture of all pins
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pin_ff1 <= 4'h3;
			pin_ff2 <= 4'h3;
			pin_ff3 <= 4'h3;
			pin_filt <= 4'h3;
			pin_prev <= 4'h3;
		end
		else if (ce_i)
		begin
			pin_ff1 <= {page_strap_i, sda_i, scl_i};
			pin_ff2 <= pin_ff1;
			pin_ff3 <= pin_ff2;
			pin_filt <= next_pin_filt;
			pin_prev <= pin_filt;
		end
	end

	assign scl_f = pin_filt[0];
	assign sda_f = pin_filt[1];
	assign scl_p = pin_prev[0];
	assign sda_p = pin_prev[1];
	// Bus conditions
	assign start_det = scl_f && scl_p && sda_p && !sda_f;
	assign stop_det = scl_f && scl_p && !sda_p && sda_f;
	assign scl_rise = scl_f && !scl_p;
	assign scl_fall = !scl_f && scl_p;

	// ------------------------------------------------------------
	// Register state and readback
	// ------------------------------------------------------------
	logic [3:0] commit_page, next_commit_page;
	logic [7:0] unlock_key, next_unlock_key;
	logic unlock_armed, next_unlock_armed;
	logic [9:0] cap_value, next_cap_value;
	logic next_commit_start, next_program_start;
	logic [AW-1:0] next_commit_base;
	logic wr_fire;
	logic [7:0] ptr, shift;
	epi_load_type ld_st, next_ld_st;

	// Register readback, unmapped reads zero
	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		reg_read = 8'h00;
		if (addr == REG_COMMIT_PAGE)
			reg_read = {4'h0, commit_page};
		else if (addr == REG_UNLOCK_KEY)
			reg_read = unlock_key;
		else if (addr == REG_NV_CONTROL)
			reg_read = {(ld_st == LD_DONE), 7'h00};
		else if (addr == REG_CAP_HIGH)
			reg_read = {6'h00, cap_value[9:8]};
		else if (addr == REG_CAP_LOW)
			reg_read = cap_value[7:0];
	endfunction

	// Register writes and request pulses
	always_comb
	begin
		next_commit_page = commit_page;
		next_unlock_key = unlock_key;
		next_unlock_armed = unlock_armed;
		next_commit_start = 1'b0;
		next_program_start = 1'b0;
		next_commit_base = commit_base_o;
		next_cap_value = crystal_load_cap_value_i;
		if (wr_fire)
		begin
			if (ptr == REG_COMMIT_PAGE)
			begin
				next_commit_page = shift[3:0];
				next_unlock_armed = 1'b0;
			end
			else if (ptr == REG_UNLOCK_KEY)
			begin
				next_unlock_key = shift;
				next_unlock_armed = (shift == UNLOCK_KEY_VALUE);
			end
			else if (ptr == REG_NV_CONTROL)
			begin
				next_program_start = shift[CTRL_PROGRAM_BIT] && unlock_armed;
				next_commit_start = shift[CTRL_COMMIT_BIT];
				next_commit_base = page_base(commit_page);
				next_unlock_armed = 1'b0;
			end
			// Any other write breaks the key sequence
			else
				next_unlock_armed = 1'b0;
		end
	end

	// Register storage
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			commit_page <= COMMIT_PAGE_RESET;
			unlock_key <= KEY_RESET;
			unlock_armed <= 1'b0;
			cap_value <= CAP_RESET;
			commit_start_o <= 1'b0;
			program_start_o <= 1'b0;
			commit_base_o <= '0;
		end
		else if (ce_i)
		begin
			commit_page <= next_commit_page;
			unlock_key <= next_unlock_key;
			unlock_armed <= next_unlock_armed;
			cap_value <= next_cap_value;
			commit_start_o <= next_commit_start;
			program_start_o <= next_program_start;
			commit_base_o <= next_commit_base;
		end
	end

	assign commit_page_o = commit_page;

	// ------------------------------------------------------------
	// Serial target
	// ------------------------------------------------------------
	epi_ser_type ser_st, next_ser_st;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] next_shift, next_ptr, rd_byte;
	logic read_mode, next_read_mode, master_ack, next_master_ack;
	logic drive, next_drive;

	// Byte to send after a master acknowledge; a process so register changes re-evaluate it
	always_comb
	begin
		rd_byte = reg_read(ptr + 8'h01);
	end
	assign wr_fire = scl_fall && !start_det && !stop_det && ser_st == SER_WDATA && bit_cnt == BYTE_BITS;

	// Bit-level protocol sequencing
	always_comb
	begin
		next_ser_st = ser_st;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_ptr = ptr;
		next_read_mode = read_mode;
		next_master_ack = master_ack;
		next_drive = drive;
		if (start_det)
		begin
			next_ser_st = SER_ADDR;
			next_bit_cnt = 4'h0;
			next_drive = 1'b0;
		end
		else if (stop_det)
		begin
			next_ser_st = SER_IDLE;
			next_drive = 1'b0;
		end
		else if (scl_rise)
		begin
			case (ser_st)
				SER_ADDR, SER_REG, SER_WDATA:
				begin
					next_shift = {shift[6:0], sda_f};
					next_bit_cnt = bit_cnt + 4'h1;
				end
				SER_RDATA_ACK: next_master_ack = !sda_f;
				default: next_ser_st = ser_st;
			endcase
		end
		else if (scl_fall)
		begin
			case (ser_st)
				SER_ADDR:
				begin
					if (bit_cnt == BYTE_BITS)
					begin
						// Acknowledge own address only
						if (shift[7:1] == DEV_ADDR)
						begin
							next_ser_st = SER_ADDR_ACK;
							next_read_mode = shift[0];
							next_drive = 1'b1;
						end
						else
							next_ser_st = SER_IDLE;
					end
				end
				SER_ADDR_ACK:
				begin
					next_bit_cnt = 4'h0;
					if (read_mode)
					begin
						// Put first read bit out
						next_ser_st = SER_RDATA;
						next_shift = reg_read(ptr);
						next_drive = !next_shift[7];
						next_bit_cnt = 4'h1;
					end
					else
					begin
						next_ser_st = SER_REG;
						next_drive = 1'b0;
					end
				end
				SER_REG:
				begin
					if (bit_cnt == BYTE_BITS)
					begin
						next_ptr = shift;
						next_ser_st = SER_REG_ACK;
						next_drive = 1'b1;
					end
				end
				SER_REG_ACK, SER_WDATA_ACK:
				begin
					next_ser_st = SER_WDATA;
					next_bit_cnt = 4'h0;
					next_drive = 1'b0;
				end
				SER_WDATA:
				begin
					if (bit_cnt == BYTE_BITS)
					begin
						// Write happens here, pointer auto-advances
						next_ptr = ptr + 8'h01;
						next_ser_st = SER_WDATA_ACK;
						next_drive = 1'b1;
					end
				end
				SER_RDATA:
				begin
					if (bit_cnt == BYTE_BITS)
					begin
						next_ser_st = SER_RDATA_ACK;
						next_drive = 1'b0;
					end
					else
					begin
						next_shift = {shift[6:0], 1'b0};
						next_drive = !shift[6];
						next_bit_cnt = bit_cnt + 4'h1;
					end
				end
				SER_RDATA_ACK:
				begin
					if (master_ack)
					begin
						next_ptr = ptr + 8'h01;
						next_shift = rd_byte;
						next_drive = !rd_byte[7];
						next_bit_cnt = 4'h1;
						next_ser_st = SER_RDATA;
					end
					else
						next_ser_st = SER_IDLE;
				end
				default: next_drive = 1'b0;
			endcase
		end
	end

	// Serial target registers
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ser_st <= SER_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			ptr <= 8'h00;
			read_mode <= 1'b0;
			master_ack <= 1'b0;
			drive <= 1'b0;
		end
		else if (ce_i)
		begin
			ser_st <= next_ser_st;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			ptr <= next_ptr;
			read_mode <= next_read_mode;
			master_ack <= next_master_ack;
			drive <= next_drive;
		end
	end

	// Open-drain: only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe_o = drive;

	// ------------------------------------------------------------
	// Power-up strap capture
	// ------------------------------------------------------------
	logic [2:0] strap_cnt, next_strap_cnt;
	logic [1:0] next_power_up_page;

	always_comb
	begin
		next_strap_cnt = strap_cnt;
		next_power_up_page = power_up_page_o;
		if (strap_cnt != STRAP_SETTLE)
			next_strap_cnt = strap_cnt + 3'h1;
		// Agreed strap level, taken on the edge the filter accepts it
		if (strap_cnt == STRAP_SETTLE - 3'h1)
			next_power_up_page = next_pin_filt[3:2];
	end

	// Strap registers
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			strap_cnt <= 3'h0;
			power_up_page_o <= 2'h0;
		end
		else if (ce_i)
		begin
			strap_cnt <= next_strap_cnt;
			power_up_page_o <= next_power_up_page;
		end
	end

	// ------------------------------------------------------------
	// Common image loader
	// ------------------------------------------------------------
	logic [3:0] ld_cnt, next_ld_cnt;
	logic [7:0] mem_rd_data;
	epi_fields_type fields, next_fields;
	logic [3:0] ld_idx;

	assign ld_idx = ld_cnt - 4'h1;

	// Walk common bytes, capture fields one cycle after address
	always_comb
	begin
		next_ld_st = ld_st;
		next_ld_cnt = ld_cnt;
		next_fields = fields;
		if (ld_st == LD_RUN)
		begin
			next_ld_cnt = ld_cnt + 4'h1;
			if (ld_cnt != 4'h0)
			begin
				if (ld_idx >= IMG_PART_ID_0 && ld_idx <= IMG_PART_ID_3)
					next_fields.part_identifier = {fields.part_identifier[23:0], mem_rd_data};
				else if (ld_idx == IMG_CHECKSUM)
					next_fields.image_checksum = mem_rd_data;
				else if (ld_idx == IMG_COUNT)
					next_fields.image_count = mem_rd_data;
				else if (ld_idx == IMG_REVISION)
					next_fields.image_revision = mem_rd_data;
				else if (ld_idx == IMG_STARTUP)
					next_fields.startup = epi_startup_type'(mem_rd_data);
			end
			if (ld_cnt == IMG_LOAD_END)
				next_ld_st = LD_DONE;
		end
	end

	// Loader registers
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ld_st <= LD_RUN;
			ld_cnt <= 4'h0;
			fields <= '0;
		end
		else if (ce_i)
		begin
			ld_st <= next_ld_st;
			ld_cnt <= next_ld_cnt;
			fields <= next_fields;
		end
	end

	assign image_fields_o = fields;
	assign image_valid_o = (ld_st == LD_DONE);

	epi_image_mem #(
		.DEPTH(IMAGE_BYTES),
		.WIDTH(8),
		.AW(AW)
	) u_mem (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.wr_i(img_wr_i),
		.wr_addr_i(img_addr_i),
		.wr_data_i(img_data_i),
		.rd_addr_i(AW'(ld_cnt)),
		.rd_data_o(mem_rd_data)
	);

endmodule // epi_image_regs

`default_nettype wire

// ===== bench/epi_i2c_host.sv
/*
 * Serial host model that drives scl and pulls sda low for the register block.
 * Assumes sda is pulled up outside and resolved by the bench from all drivers.
 */
`timescale 1ns/100ps
`default_nettype none

module epi_i2c_host
	import epi_pkg::*;
#(
	parameter int unsigned Q = 10
)
(
	// Clock and resolved line
	input wire logic sys_clk_i,
	input wire logic sda_line_i,
	// Host drivers
	output logic scl_o,
	output logic sda_low_o
);
	int nacks = 0; // Missing target acks
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// Wait a number of clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	// Start, or repeated start when scl is low
	task automatic start_cond();
		sda_low_o <= 1'b0;
		tick(Q);
		scl_o <= 1'b1;
		tick(Q);
		sda_low_o <= 1'b1;
		tick(Q);
		scl_o <= 1'b0;
		tick(Q);
	endtask
	task automatic stop_cond();
		sda_low_o <= 1'b1;
		tick(Q);
		scl_o <= 1'b1;
		tick(Q);
		sda_low_o <= 1'b0;
		tick(Q);
	endtask
	// Nine bits, MSB first; data changes only while scl is low
	task automatic xfer(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			sda_low_o <= !w[i];
			tick(Q);
			scl_o <= 1'b1;
			tick(Q);
			r[i] = sda_line_i;
			tick(Q);
			scl_o <= 1'b0;
			tick(Q);
		end
	endtask
	// Byte out, target ack expected
	task automatic put(input logic [7:0] d);
		logic [8:0] r;
		xfer({d, 1'b1}, r);
		if (r[0] !== 1'b0)
			nacks++;
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		start_cond();
		put({7'h50, 1'b0});
		put(a);
		put(d);
		stop_cond();
	endtask
	// Pointer write, repeated start, one byte read ended by nack
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] r;
		start_cond();
		put({7'h50, 1'b0});
		put(a);
		start_cond();
		put({7'h50, 1'b1});
		xfer(9'h1ff, r);
		d = r[8:1];
		stop_cond();
	endtask
	// Two bytes from pointer: host ack after the first, nack after the second
	task automatic read_two(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
		logic [8:0] r;
		start_cond();
		put({7'h50, 1'b0});
		put(a);
		start_cond();
		put({7'h50, 1'b1});
		xfer(9'h1fe, r);
		d0 = r[8:1];
		xfer(9'h1ff, r);
		d1 = r[8:1];
		stop_cond();
	endtask
endmodule // epi_i2c_host

`default_nettype wire

// ===== bench/epi_image_regs_chk.sv
/*
 * Port checker for the configuration image register block.
 * Assumes one clock, async active-low reset, bound to the top module.
 */
`timescale 1ns/100ps
`default_nettype none

module epi_image_regs_chk
	import epi_pkg::*;
#(
	parameter int unsigned AW = 9
)
(
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Pins
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [1:0] page_strap_i,
	// Outputs
	input wire logic [3:0] commit_page_o,
	input wire logic [AW-1:0] commit_base_o,
	input wire logic commit_start_o,
	input wire logic program_start_o,
	input wire logic [1:0] power_up_page_o,
	input wire epi_fields_type image_fields_o,
	input wire logic image_valid_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	logic [4:0] cnt; // Enabled edges since reset
	logic [1:0] strap_cap; // Strap level at release
	// Edge counter and strap capture
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt <= 5'h00;
			strap_cap <= 2'h0;
		end
		else if (ce_i && cnt != 5'h1f)
		begin
			cnt <= cnt + 5'h01;
			if (cnt == 5'h00)
				strap_cap <= page_strap_i;
		end
	end
	reset_values_a: assert property (cnt == 5'h00 |-> commit_page_o == 4'h0 && image_fields_o == '0 && !image_valid_o) else $error("outputs not at reset value");
	strap_page_a: assert property (cnt >= 5'h06 |-> power_up_page_o == strap_cap) else $error("power-up page differs from strap");
	commit_base_a: assert property (commit_start_o |-> commit_base_o == AW'(COMMON_BYTES + commit_page_o * PAGE_BYTES)) else $error("commit base wrong");
	commit_pulse_a: assert property (commit_start_o |-> !scl_i ##1 !commit_start_o) else $error("commit pulse too long");
	program_pulse_a: assert property (program_start_o |-> !scl_i ##1 !program_start_o) else $error("program pulse too long");
	valid_early_a: assert property (cnt < 5'h0e |-> !image_valid_o) else $error("image valid too early");
	valid_late_a: assert property (cnt >= 5'h10 |-> image_valid_o) else $error("image valid missing");
	fields_hold_a: assert property (image_valid_o && $past(image_valid_o) |-> $stable(image_fields_o)) else $error("fields moved after load");
	ack_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i && sda_o == 1'b0) else $error("sda drive changed with scl high");
	commit_cov: cover property (commit_start_o && commit_page_o == 4'h5);
	program_cov: cover property (program_start_o);
	load_cov: cover property ($rose(image_valid_o));
endmodule // epi_image_regs_chk

bind epi_image_regs epi_image_regs_chk #(.AW(AW)) u_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
	.ce_i(ce_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .page_strap_i(page_strap_i),
	.commit_page_o(commit_page_o), .commit_base_o(commit_base_o), .commit_start_o(commit_start_o),
	.program_start_o(program_start_o), .power_up_page_o(power_up_page_o), .image_fields_o(image_fields_o),
	.image_valid_o(image_valid_o));

`default_nettype wire

// ===== bench/eeprom_page_image_regs_tb_top.sv
/*
 * Self-checking bench: registers over the serial host model, image loader.
 * Assumes a pull-up on sda and a 10 MHz system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module eeprom_page_image_regs_tb_top;
	import epi_pkg::*;
	logic sys_clk, arst_n, ce, img_wr, scl, host_low, sda_oe, sda_o, cstart, pstart, valid;
	logic [8:0] img_addr, cbase, last_base;
	logic [7:0] img_data, rd, rd2;
	logic [1:0] pup, strap;
	logic [9:0] cap;
	logic [3:0] cpage;
	epi_fields_type fields;
	wire sda_line = !(host_low || (sda_oe && !sda_o)); // Pull-up
	int fail_count = 0, check_count = 0, commits = 0, progs = 0;

	epi_i2c_host u_host (.sys_clk_i(sys_clk), .sda_line_i(sda_line), .scl_o(scl), .sda_low_o(host_low));
	epi_image_regs u_dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .ce_i(ce), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .page_strap_i(strap), .crystal_load_cap_value_i(cap),
		.img_wr_i(img_wr), .img_addr_i(img_addr), .img_data_i(img_data), .commit_page_o(cpage),
		.commit_base_o(cbase), .commit_start_o(cstart), .program_start_o(pstart), .power_up_page_o(pup),
		.image_fields_o(fields), .image_valid_o(valid));

	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = !sys_clk;
	end
	// Pulse monitor
	always @(posedge sys_clk)
	begin
		if (cstart === 1'b1)
		begin
			commits++;
			last_base = cbase;
		end
		if (pstart === 1'b1)
			progs++;
	end
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected word at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic [7:0] img(input int i);
		return 8'(i * 19 + 33);
	endfunction
	// Expected common fields when byte i holds img(i + k)
	function automatic logic [63:0] exp_fields(input int k);
		return {img(k), img(k + 1), img(k + 2), img(k + 3), img(k + 4), img(k + 5), img(k + 12), img(k + 13)};
	endfunction
	// Image bytes 0..13, one per cycle, while reset holds the loader
	task automatic load_image(input int k);
		for (int i = 0; i < 14; i++)
		begin
			img_wr <= 1'b1;
			img_addr <= 9'(i);
			img_data <= img(i + k);
			@(posedge sys_clk);
		end
		img_wr <= 1'b0;
	endtask
	// Watchdog
	initial
	begin
		repeat (80000) @(posedge sys_clk);
		fail_count++;
		wrap_up();
	end
	initial
	begin
		arst_n <= 1'b0;
		ce <= 1'b1;
		strap <= 2'h2;
		cap <= 10'h2a5;
		img_wr <= 1'b0;
		img_addr <= 9'h000;
		img_data <= 8'h00;
		// Image written during the 16 reset cycles
		repeat (2) @(posedge sys_clk);
		load_image(0);
		arst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cmp_word(cpage, 64'h0);
		repeat (16) @(posedge sys_clk);
		cmp_word(valid, 64'h1);
		cmp_word(fields, exp_fields(0));
		cmp_word(pup, 64'h2);
		u_host.read_reg(REG_COMMIT_PAGE, rd);
		cmp_byte(rd, 8'h00);
		u_host.read_reg(REG_CAP_HIGH, rd);
		cmp_byte(rd, 8'h02);
		u_host.write_reg(REG_CAP_LOW, 8'h00);
		u_host.read_reg(REG_CAP_LOW, rd);
		cmp_byte(rd, 8'ha5);
		u_host.read_reg(8'h55, rd);
		cmp_byte(rd, 8'h00);
		// New trim value, both halves in one auto-increment read
		cap <= 10'h15a;
		u_host.read_two(REG_CAP_HIGH, rd, rd2);
		cmp_byte(rd, 8'h01);
		cmp_byte(rd2, 8'h5a);
		// Pages zero to five only, reserved nibble zero
		// Legal page codes
		for (int p = 0; p < 6; p++)
		begin
			u_host.write_reg(REG_COMMIT_PAGE, 8'(p));
			u_host.read_reg(REG_COMMIT_PAGE, rd);
			cmp_byte(rd, 8'(p));
			cmp_word(cpage, 64'(p));
			u_host.write_reg(REG_NV_CONTROL, 8'h02);
			u_host.tick(4);
			cmp_word(commits, 64'(p + 1));
			cmp_word(last_base, 64'(39 + p * 51));
		end
		// Key just before program bit
		u_host.write_reg(REG_UNLOCK_KEY, UNLOCK_KEY_VALUE);
		u_host.write_reg(REG_NV_CONTROL, 8'h01);
		u_host.tick(4);
		cmp_word(progs, 64'h1);
		// Key broken by another write
		u_host.write_reg(REG_UNLOCK_KEY, UNLOCK_KEY_VALUE);
		u_host.write_reg(REG_COMMIT_PAGE, 8'h00);
		u_host.write_reg(REG_NV_CONTROL, 8'h01);
		u_host.tick(4);
		cmp_word(progs, 64'h1);
		// Mid-run reset reloads a new image; enable low freezes the loader
		strap <= 2'h1;
		arst_n <= 1'b0;
		load_image(1);
		arst_n <= 1'b1;
		ce <= 1'b0;
		repeat (30) @(posedge sys_clk);
		cmp_word(valid, 64'h0);
		ce <= 1'b1;
		repeat (20) @(posedge sys_clk);
		cmp_word(valid, 64'h1);
		cmp_word(fields, exp_fields(1));
		cmp_word(pup, 64'h1);
		cmp_word(cpage, 64'h0);
		cmp_word(u_host.nacks, 64'h0);
		wrap_up();
	end
endmodule // eeprom_page_image_regs_tb_top

`default_nettype wire
